// File: design/lsr_readout_regs.sv
// Purpose: Read-only result, status and identity registers behind a serial slave port
// Assumes: Conversion results arrive on clk; serial pins are oversampled on link_clk
// Notes: Results cross to link_clk by a toggle handshake carrying a held word
`timescale 1ns/1ps
module lsr_readout_regs #(
  parameter logic [6:0] SLAVE_ADDR = lsr_pkg::SLAVE_ADDR_DEFAULT,
  parameter logic [7:0] PART_IDENTITY = lsr_pkg::PART_IDENTITY_DEFAULT // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic light_sense_enable,
  input wire logic conv_done,
  input wire logic [15:0] first_count,
  input wire logic [15:0] second_count,
  input wire logic light_irq_assert,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic int_o,
  output logic int_oe
);

  // Core side: status flags and the word offered to the link
  logic valid_reg, valid_next; // Result valid flag
  logic irq_reg, irq_next; // Registered interrupt level
  logic [31:0] hold_reg, hold_next; // Word under transfer, stable while busy
  logic [31:0] latest_reg, latest_next; // Newest result, sent after busy
  logic pend_reg, pend_next; // Newer result waiting
  logic req_reg, req_next; // Request toggle
  logic ack_s1_reg, ack_s2_reg; // Acknowledge synchroniser
  logic busy; // Transfer outstanding

  // Link side synchronisers and state
  logic ack_reg, ack_next; // Acknowledge toggle
  logic req_s1_reg, req_s2_reg, req_s3_reg; // Request synchroniser plus edge stage
  logic vld_s1_reg, vld_s2_reg; // Valid level crossing
  logic irq_s1_reg, irq_s2_reg; // Interrupt level crossing
  logic [15:0] cnt0_reg, cnt0_next; // First count, link copy
  logic [15:0] cnt1_reg, cnt1_next; // Second count, link copy
  logic [7:0] shadow0_reg, shadow0_next; // First count upper byte latch
  logic [7:0] shadow1_reg, shadow1_next; // Second count upper byte latch
  logic [2:0] scl_sync_reg, sda_sync_reg; // Pin sampling chains
  logic scl_f_reg, scl_f_next; // Filtered clock line
  logic sda_f_reg, sda_f_next; // Filtered data line
  lsr_pkg::lsr_state_t state_reg, state_next; // Serial engine state
  lsr_pkg::lsr_kind_t kind_reg, kind_next; // Byte being received
  logic [3:0] bit_reg, bit_next; // Bit count within a byte
  logic [7:0] shift_reg, shift_next; // Shift register, both directions
  logic [4:0] ptr_reg, ptr_next; // Register pointer
  logic auto_reg, auto_next; // Auto increment selected
  logic rd_reg, rd_next; // Current transfer is a read
  logic mack_reg, mack_next; // Host acknowledged last byte
  logic oe_reg, oe_next; // Data line pull-down
  logic scl_rise, scl_fall, start_det, stop_det; // Line events
  logic [4:0] load_ptr; // Pointer of the byte to send next
  logic [7:0] rd_byte; // Read mux output
  logic [7:0] status_byte; // Assembled status

  // Handshake busy while acknowledge lags request
  assign busy = req_reg ^ ack_s2_reg;

  // Core next state: valid flag, result hand-off
  always_comb begin
    valid_next = valid_reg;
    irq_next = light_irq_assert; // Threshold logic outside compares first count only
    hold_next = hold_reg;
    latest_next = latest_reg;
    pend_next = pend_reg;
    req_next = req_reg;
    if (!light_sense_enable) begin
      valid_next = 1'b0;
    end else if (conv_done) begin
      valid_next = 1'b1;
    end
    if (conv_done) begin
      latest_next = {second_count, first_count};
      pend_next = 1'b1;
    end
    // Only start a new transfer when the last one is acknowledged
    if (!busy && (pend_reg || conv_done)) begin
      hold_next = conv_done ? {second_count, first_count} : latest_reg;
      req_next = ~req_reg;
      pend_next = 1'b0;
    end
  end

  // Core registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid_reg <= 1'b0;
      irq_reg <= 1'b0;
      hold_reg <= {lsr_pkg::COUNT_RESET, lsr_pkg::COUNT_RESET};
      latest_reg <= {lsr_pkg::COUNT_RESET, lsr_pkg::COUNT_RESET};
      pend_reg <= 1'b0;
      req_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      valid_reg <= valid_next;
      irq_reg <= irq_next;
      hold_reg <= hold_next;
      latest_reg <= latest_next;
      pend_reg <= pend_next;
      req_reg <= req_next;
      ack_s1_reg <= ack_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  // Open-drain interrupt: pull low while asserted, never drive high
  assign int_o = 1'b0;
  assign int_oe = irq_reg;

  // Data line only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = oe_reg;

  // Line events from filtered levels
  assign scl_rise = scl_f_next & ~scl_f_reg;
  assign scl_fall = ~scl_f_next & scl_f_reg;
  assign start_det = scl_f_reg & scl_f_next & sda_f_reg & ~sda_f_next;
  assign stop_det = scl_f_reg & scl_f_next & ~sda_f_reg & sda_f_next;

  // Status assembled with reserved bits at zero
  always_comb begin
    status_byte = lsr_pkg::BYTE_RESET;
    status_byte[lsr_pkg::STATUS_IRQ_BIT] = irq_s2_reg;
    status_byte[lsr_pkg::STATUS_VALID_BIT] = vld_s2_reg;
  end

  // Next pointer: step only in auto increment mode after a host acknowledge
  assign load_ptr = (mack_reg && auto_reg) ? ptr_reg + 5'h01 : ptr_reg;

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (load_ptr)
      lsr_pkg::ADDR_PART_IDENTITY: rd_byte = PART_IDENTITY;
      lsr_pkg::ADDR_SENSOR_STATUS: rd_byte = status_byte;
      lsr_pkg::ADDR_CHAN0_COUNT_LOW: rd_byte = cnt0_reg[7:0];
      lsr_pkg::ADDR_CHAN0_COUNT_HIGH: rd_byte = shadow0_reg;
      lsr_pkg::ADDR_CHAN1_COUNT_LOW: rd_byte = cnt1_reg[7:0];
      lsr_pkg::ADDR_CHAN1_COUNT_HIGH: rd_byte = shadow1_reg;
      default: rd_byte = lsr_pkg::BYTE_RESET;
    endcase
  end

  // Link next state: pin filter, result capture, serial engine
  always_comb begin
    scl_f_next = scl_f_reg;
    sda_f_next = sda_f_reg;
    ack_next = ack_reg;
    cnt0_next = cnt0_reg;
    cnt1_next = cnt1_reg;
    shadow0_next = shadow0_reg;
    shadow1_next = shadow1_reg;
    state_next = state_reg;
    kind_next = kind_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    auto_next = auto_reg;
    rd_next = rd_reg;
    mack_next = mack_reg;
    oe_next = oe_reg;
    // A pin level counts once the second and third stage agree
    if (scl_sync_reg[1] == scl_sync_reg[2]) begin
      scl_f_next = scl_sync_reg[2];
    end
    if (sda_sync_reg[1] == sda_sync_reg[2]) begin
      sda_f_next = sda_sync_reg[2];
    end
    // New result: counts update, shadow latches stay put
    if (req_s2_reg != req_s3_reg) begin
      cnt0_next = hold_reg[15:0];
      cnt1_next = hold_reg[31:16];
      ack_next = req_s2_reg;
    end
    if (stop_det) begin
      // Stop ends any transfer and frees the line
      state_next = lsr_pkg::LSR_IDLE;
      oe_next = 1'b0;
    end else if (start_det) begin
      // Start or repeated start: expect the address byte
      state_next = lsr_pkg::LSR_RX;
      kind_next = lsr_pkg::LSR_KIND_ADDR;
      bit_next = 4'h0;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        lsr_pkg::LSR_IDLE: begin
          oe_next = 1'b0;
        end
        lsr_pkg::LSR_RX: begin
          if (scl_rise && bit_reg != lsr_pkg::BITS_PER_BYTE) begin
            shift_next = {shift_reg[6:0], sda_f_reg};
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == lsr_pkg::BITS_PER_BYTE) begin
            bit_next = 4'h0;
            state_next = lsr_pkg::LSR_RX_ACK;
            oe_next = 1'b1;
            case (kind_reg)
              lsr_pkg::LSR_KIND_ADDR: begin
                rd_next = shift_reg[0];
                mack_next = 1'b0;
                // Other addresses are left alone, no acknowledge
                if (shift_reg[7:1] != SLAVE_ADDR) begin
                  state_next = lsr_pkg::LSR_IDLE;
                  oe_next = 1'b0;
                end
              end
              lsr_pkg::LSR_KIND_CMD: begin
                if (shift_reg[lsr_pkg::CMD_SELECT_BIT]) begin
                  ptr_next = shift_reg[4:0];
                  auto_next = (shift_reg[6:5] == lsr_pkg::CMD_TYPE_AUTO_INC);
                end
              end
              // Data writes are acknowledged and dropped: every register here is read only
              lsr_pkg::LSR_KIND_DATA: begin
                ptr_next = ptr_reg;
              end
              default: begin
                state_next = lsr_pkg::LSR_IDLE;
                oe_next = 1'b0;
              end
            endcase
          end
        end
        lsr_pkg::LSR_RX_ACK: begin
          if (scl_fall) begin
            if (rd_reg) begin
              // First read byte goes out on this same falling edge
              ptr_next = load_ptr;
              shift_next = rd_byte;
              oe_next = ~rd_byte[7];
              bit_next = 4'h1;
              state_next = lsr_pkg::LSR_TX;
              if (load_ptr == lsr_pkg::ADDR_CHAN0_COUNT_LOW) begin
                shadow0_next = cnt0_reg[15:8];
              end
              if (load_ptr == lsr_pkg::ADDR_CHAN1_COUNT_LOW) begin
                shadow1_next = cnt1_reg[15:8];
              end
            end else begin
              oe_next = 1'b0;
              state_next = lsr_pkg::LSR_RX;
              kind_next = (kind_reg == lsr_pkg::LSR_KIND_ADDR) ? lsr_pkg::LSR_KIND_CMD : lsr_pkg::LSR_KIND_DATA;
            end
          end
        end
        lsr_pkg::LSR_TX: begin
          if (scl_fall) begin
            if (bit_reg == lsr_pkg::BITS_PER_BYTE) begin
              // Release for the host acknowledge bit
              oe_next = 1'b0;
              mack_next = 1'b0;
              state_next = lsr_pkg::LSR_TX_ACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next = ~shift_reg[6];
              bit_next = bit_reg + 4'h1;
            end
          end
        end
        lsr_pkg::LSR_TX_ACK: begin
          if (scl_rise) begin
            // High level is a not-acknowledge: the read is over
            if (sda_f_reg) begin
              state_next = lsr_pkg::LSR_IDLE;
            end else begin
              mack_next = 1'b1;
            end
          end else if (scl_fall && mack_reg) begin
            ptr_next = load_ptr;
            shift_next = rd_byte;
            oe_next = ~rd_byte[7];
            bit_next = 4'h1;
            mack_next = 1'b0;
            state_next = lsr_pkg::LSR_TX;
            if (load_ptr == lsr_pkg::ADDR_CHAN0_COUNT_LOW) begin
              shadow0_next = cnt0_reg[15:8];
            end
            if (load_ptr == lsr_pkg::ADDR_CHAN1_COUNT_LOW) begin
              shadow1_next = cnt1_reg[15:8];
            end
          end
        end
        default: begin
          state_next = lsr_pkg::LSR_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  // Link registers
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
      vld_s1_reg <= 1'b0;
      vld_s2_reg <= 1'b0;
      irq_s1_reg <= 1'b0;
      irq_s2_reg <= 1'b0;
      ack_reg <= 1'b0;
      cnt0_reg <= lsr_pkg::COUNT_RESET;
      cnt1_reg <= lsr_pkg::COUNT_RESET;
      shadow0_reg <= lsr_pkg::BYTE_RESET;
      shadow1_reg <= lsr_pkg::BYTE_RESET;
      state_reg <= lsr_pkg::LSR_IDLE;
      kind_reg <= lsr_pkg::LSR_KIND_ADDR;
      bit_reg <= 4'h0;
      shift_reg <= lsr_pkg::BYTE_RESET;
      ptr_reg <= lsr_pkg::PTR_RESET;
      auto_reg <= 1'b0;
      rd_reg <= 1'b0;
      mack_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      scl_f_reg <= scl_f_next;
      sda_f_reg <= sda_f_next;
      req_s1_reg <= req_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      vld_s1_reg <= valid_reg;
      vld_s2_reg <= vld_s1_reg;
      irq_s1_reg <= irq_reg;
      irq_s2_reg <= irq_s1_reg;
      ack_reg <= ack_next;
      cnt0_reg <= cnt0_next;
      cnt1_reg <= cnt1_next;
      shadow0_reg <= shadow0_next;
      shadow1_reg <= shadow1_next;
      state_reg <= state_next;
      kind_reg <= kind_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      auto_reg <= auto_next;
      rd_reg <= rd_next;
      mack_reg <= mack_next;
      oe_reg <= oe_next;
    end
  end

endmodule // lsr_readout_regs

// File: include/lsr_pkg.sv
// Purpose: Shared constants and types for the light sensor readout register group
// Assumes: Byte-wide registers addressed by a 5-bit pointer from the serial command byte
// Notes: Offsets are register addresses as seen by the serial host
package lsr_pkg;

  // Register addresses
  localparam logic [4:0] ADDR_PART_IDENTITY = 5'h12;
  localparam logic [4:0] ADDR_SENSOR_STATUS = 5'h13;
  localparam logic [4:0] ADDR_CHAN0_COUNT_LOW = 5'h14;
  localparam logic [4:0] ADDR_CHAN0_COUNT_HIGH = 5'h15;
  localparam logic [4:0] ADDR_CHAN1_COUNT_LOW = 5'h16;
  localparam logic [4:0] ADDR_CHAN1_COUNT_HIGH = 5'h17;

  // Status field positions
  localparam int STATUS_IRQ_BIT = 4;
  localparam int STATUS_VALID_BIT = 0;

  // Command byte layout
  localparam int CMD_SELECT_BIT = 7;
  localparam logic [1:0] CMD_TYPE_AUTO_INC = 2'h1;

  // Values after reset and on unmapped reads, and bits per byte
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [4:0] PTR_RESET = 5'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Default serial slave address of the device
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h39;
  // Arbitrary neutral identity value
  localparam logic [7:0] PART_IDENTITY_DEFAULT = 8'hA5;

  // Serial engine states
  typedef enum logic [4:0] {
    LSR_IDLE = 5'h01,
    LSR_RX = 5'h02,
    LSR_RX_ACK = 5'h04,
    LSR_TX = 5'h08,
    LSR_TX_ACK = 5'h10
  } lsr_state_t;

  // Which byte of a write the receiver is on
  typedef enum logic [2:0] {
    LSR_KIND_ADDR = 3'h1,
    LSR_KIND_CMD = 3'h2,
    LSR_KIND_DATA = 3'h4
  } lsr_kind_t;

endpackage

// File: verif/lsr_readout_regs_monitor.sv
// Purpose: Port checker for the readout register group
// Assumes: Serial clock phases of at least 8 link cycles
// Notes: Open-drain pins are judged by their enables
`timescale 1ns/1ps
module lsr_readout_regs_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic light_sense_enable,
  input wire logic conv_done,
  input wire logic [15:0] first_count,
  input wire logic [15:0] second_count,
  input wire logic light_irq_assert,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic int_o,
  input wire logic int_oe
);
  // Pins only ever pull low, never drive high
  property p_sda_pull; @(posedge link_clk) disable iff (rst) sda_o == 1'b0; endproperty
  a_sda_pull: assert property (p_sda_pull) else $error("sda_o high");
  property p_int_pull; @(posedge clk) disable iff (rst) int_o == 1'b0; endproperty
  a_int_pull: assert property (p_int_pull) else $error("int_o high");
  // Interrupt pin tracks the condition one cycle later
  property p_int_on; @(posedge clk) disable iff (rst) light_irq_assert |=> int_oe; endproperty
  a_int_on: assert property (p_int_on) else $error("int not pulled");
  property p_int_off; @(posedge clk) disable iff (rst) !light_irq_assert |=> !int_oe; endproperty
  a_int_off: assert property (p_int_off) else $error("int not released");
  // Both pins released as reset ends
  property p_int_rst; @(posedge clk) disable iff (rst) $fell(rst) |-> !int_oe; endproperty
  a_int_rst: assert property (p_int_rst) else $error("int pulled after reset");
  property p_sda_rst; @(posedge link_clk) disable iff (rst) $fell(rst) |-> !sda_oe; endproperty
  a_sda_rst: assert property (p_sda_rst) else $error("sda pulled after reset");
  // Data moves only while the serial clock is low, so no false start or stop
  property p_sda_move; @(posedge link_clk) disable iff (rst) $changed(sda_oe) |-> !scl_i; endproperty
  a_sda_move: assert property (p_sda_move) else $error("sda moved with scl high");
  // A pulled bit stands for at least 8 link cycles after it rises
  property p_sda_hold; @(posedge link_clk) disable iff (rst) $rose(sda_oe) |=> sda_oe [*8]; endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("sda bit too short");
endmodule // lsr_readout_regs_monitor
bind lsr_readout_regs lsr_readout_regs_monitor lsr_readout_regs_monitor_inst (.clk(clk), .rst(rst), .link_clk(link_clk),
  .light_sense_enable(light_sense_enable), .conv_done(conv_done), .first_count(first_count), .int_o(int_o),
  .second_count(second_count), .light_irq_assert(light_irq_assert), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .int_oe(int_oe));

// File: verif/lsr_i2c_host_model.sv
// Purpose: Serial host model for register reads and writes
// Assumes: Pull-ups on both lines; 8 link cycles per clock phase
// Notes: Pulls low or releases only; each received byte pulses rd_valid
`timescale 1ns/1ps
module lsr_i2c_host_model (
  input wire logic link_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low,
  output logic rd_valid,
  output logic [7:0] rd_byte
);
  localparam logic [6:0] DEV = lsr_pkg::SLAVE_ADDR_DEFAULT;
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_valid = 1'b0;
  end
  // Set both lines, hold n link cycles, step off the edge
  task automatic ph(input logic s, input logic d, input int n);
    scl = s;
    sda_low = d;
    repeat (n) @(posedge link_clk);
    #1;
  endtask
  // One bit out, data stable through the high phase
  task automatic put(input logic b);
    ph(1'b0, ~b, 4);
    ph(1'b1, ~b, 8);
    ph(1'b0, ~b, 4);
  endtask
  // One bit in, sampled mid high phase
  task automatic get(output logic b);
    ph(1'b0, 1'b0, 4);
    ph(1'b1, 1'b0, 4);
    b = sda_line;
    ph(1'b1, 1'b0, 4);
    ph(1'b0, 1'b0, 4);
  endtask
  // Start or repeated start: data falls with clock high
  task automatic start();
    ph(1'b0, 1'b0, 4);
    ph(1'b1, 1'b0, 8);
    ph(1'b1, 1'b1, 8);
    ph(1'b0, 1'b1, 4);
  endtask
  // Stop: data rises with clock high
  task automatic stop();
    ph(1'b0, 1'b1, 4);
    ph(1'b1, 1'b1, 8);
    ph(1'b1, 1'b0, 8);
  endtask
  // Byte out MSB first; acknowledge not acted on
  task automatic send(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--)
      put(v[i]);
    get(a);
  endtask
  // Byte in, then acknowledge or, on the last, not
  task automatic recv(input logic last);
    logic [7:0] v;
    for (int i = 7; i >= 0; i--)
      get(v[i]);
    rd_byte = v;
    rd_valid = 1'b1;
    ph(1'b0, 1'b0, 1);
    rd_valid = 1'b0;
    put(last);
  endtask
  // Pointer write then one auto-increment read of n bytes
  task automatic read_regs(input logic [4:0] a, input int n);
    start();
    send({DEV, 1'b0});
    send({1'b1, lsr_pkg::CMD_TYPE_AUTO_INC, a});
    start();
    send({DEV, 1'b1});
    for (int i = 0; i < n; i++)
      recv(i == n - 1);
    stop();
  endtask
  // Two data bytes written from address a onward
  task automatic write_regs(input logic [4:0] a, input logic [7:0] d);
    start();
    send({DEV, 1'b0});
    send({1'b1, lsr_pkg::CMD_TYPE_AUTO_INC, a});
    send(d);
    send(~d);
    stop();
  endtask
endmodule // lsr_i2c_host_model

// File: verif/light_sensor_readout_regs_test.sv
// Purpose: Self-checking bench for the readout register group
// Assumes: Host model on link_clk; results injected on clk
// Notes: Expected bytes queued by the driver, popped per received byte
`timescale 1ns/1ps
module light_sensor_readout_regs_test;
  logic clk, link_clk, rst, light_sense_enable, conv_done, light_irq_assert;
  logic irq_bit; // Random interrupt level for the last status check
  logic [15:0] first_count, second_count, c0, c1, n0, n1;
  logic sda_i, sda_o, sda_oe, int_o, int_oe, scl, sda_low, rd_valid;
  logic [7:0] rd_byte, exp_v;
  logic [7:0] exp_q[$]; // Expected read bytes in order
  int bad_count, compares, cycles, seed;
  localparam int LIMIT = 60000; // About one and a half times the expected run
  // Wired data line with pull-up
  assign sda_i = ~(sda_low | sda_oe);
  lsr_readout_regs lsr_readout_regs_inst (
    .clk(clk),
    .rst(rst),
    .link_clk(link_clk),
    .light_sense_enable(light_sense_enable),
    .conv_done(conv_done),
    .first_count(first_count),
    .second_count(second_count),
    .light_irq_assert(light_irq_assert),
    .scl_i(scl),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .int_o(int_o),
    .int_oe(int_oe)
  );
  lsr_i2c_host_model lsr_i2c_host_model_inst (
    .link_clk(link_clk),
    .sda_line(sda_i),
    .scl(scl),
    .sda_low(sda_low),
    .rd_valid(rd_valid),
    .rd_byte(rd_byte)
  );
  // Core clock, 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Link clock, 48 ns, offset so edges never meet core edges
  initial begin
    link_clk = 1'b0;
    #5;
    forever #24 link_clk = ~link_clk;
  end
  // Verdict and end of run
  task automatic tally_and_finish();
    if (exp_q.size() != 0)
      bad_count++;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One finished conversion
  task automatic pulse(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    #1;
    first_count = a;
    second_count = b;
    conv_done = 1'b1;
    @(posedge clk);
    #1;
    conv_done = 1'b0;
    repeat (10) @(posedge link_clk);
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input int n);
    lsr_i2c_host_model_inst.read_regs(a, n);
  endtask
  // Compare every received byte with the oldest note
  always @(posedge link_clk) begin
    if (rd_valid === 1'b1) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : ~rd_byte;
      compares++;
      if (rd_byte !== exp_v) begin
        bad_count++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, rd_byte, exp_v);
      end
    end
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // Main sequence
  initial begin
    seed = 95;
    rst = 1'b1;
    light_sense_enable = 1'b1;
    conv_done = 1'b0;
    first_count = 16'h0000;
    second_count = 16'h0000;
    light_irq_assert = 1'b0;
    bad_count = 0;
    compares = 0;
    cycles = 0;
    c0 = 16'($random(seed));
    c1 = 16'($random(seed));
    n0 = 16'($random(seed));
    n1 = 16'($random(seed));
    irq_bit = 1'($random(seed));
    // Reset spans two edges of the slower clock
    repeat (2) @(posedge link_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge link_clk);
    #1 light_irq_assert = 1'b1;
    pulse(c0, c1);
    exp_q.push_back(8'h11);
    rd(5'h13, 1);
    // Writes to identity and status change nothing
    lsr_i2c_host_model_inst.write_regs(5'h12, 8'h5A);
    exp_q.push_back(lsr_pkg::PART_IDENTITY_DEFAULT);
    exp_q.push_back(8'h11);
    rd(5'h12, 2);
    // New result lands after the low byte has gone out
    light_irq_assert = 1'b0;
    exp_q.push_back(c0[7:0]);
    exp_q.push_back(c0[15:8]);
    exp_q.push_back(n1[7:0]);
    exp_q.push_back(n1[15:8]);
    fork
      rd(5'h14, 4);
      begin
        @(posedge rd_valid);
        pulse(n0, n1);
      end
    join
    // Lone high read gives the latched byte, not the newer count
    exp_q.push_back(c0[15:8]);
    rd(5'h15, 1);
    // Unmapped places read zero
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    rd(5'h1E, 2);
    // Disable drops valid; re-enable waits for a fresh result
    // Enable flips off here and back on below
    light_sense_enable = ~light_sense_enable;
    exp_q.push_back(8'h00);
    rd(5'h13, 1);
    light_sense_enable = ~light_sense_enable;
    exp_q.push_back(8'h00);
    rd(5'h13, 1);
    // Random interrupt level: status bit 4 must follow it
    light_irq_assert = irq_bit;
    pulse(n0, n1);
    exp_q.push_back({3'h0, irq_bit, 3'h0, 1'b1});
    rd(5'h13, 1);
    tally_and_finish();
  end
endmodule // light_sensor_readout_regs_test
